// File: rtl/sacs_defs.svh
// constants for the serial converter sequencer and its host end
`ifndef SACS_DEFS_SVH
`define SACS_DEFS_SVH
`define SACS_CLK_MHZ        250
`define SACS_SCLK_MIN_NS    1000
`define SACS_SCLK_HALF_CYC  ((`SACS_SCLK_MIN_NS * `SACS_CLK_MHZ + 1999) / 2000)
`define SACS_ADDR_BITS      3
`define SACS_SEL_BITS       4
`define SACS_SAMPLE_EDGES   9
`define SACS_CONV_CCLKS     41
`define SACS_LEFT_BITS      10
`define SACS_RIGHT_BITS     16
`define SACS_RES_BITS       10
`define SACS_PAD_BITS       6
`define SACS_CHANNELS       8
`define SACS_CNT_W          7
`endif

// File: rtl/sacs_device.sv
// converter side: select shift-in, sampling window, conversion timing, result shift-out
`timescale 1ns/100ps
`include "sacs_defs.svh"
module sacs_device
  import sacs_pkg::*;
(
  input  wire logic                                            clock,
  input  wire logic                                            rst_b,
  sacs_link_if.dev                                             link,
  input  wire logic [`SACS_CHANNELS-1:0][`SACS_RES_BITS-1:0]   analog_in,
  output logic      [`SACS_ADDR_BITS-1:0]                      selected_channel,
  output logic                                                 sampling
);

  sacs_dev_state_e                    state;
  logic                               sclk_q;
  logic                               conversion_clock_q;
  logic [`SACS_CNT_W-1:0]             cnt;
  logic [`SACS_ADDR_BITS-1:0]         addr_sr;
  logic                               right_just;
  logic [`SACS_RES_BITS-1:0]          held;
  logic [`SACS_RIGHT_BITS-1:0]        shift_reg;
  logic                               rise_seen;
  logic                               busy;
  logic                               sclk_rise;
  logic                               sclk_fall;
  logic                               conversion_clock_rise;
  logic                               conv_start;
  logic                               conv_done;
  logic                               addr_rise;
  logic                               last_select;
  logic [`SACS_CHANNELS-1:0][`SACS_RES_BITS-1:0] gated;
  logic [`SACS_RES_BITS-1:0]          picked;

  // link pins are synchronous to clock, so one stage is enough for edges
  // both stages reset low, the idle level, so no false edge follows reset
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      sclk_q <= 1'b0;
    end else begin
      sclk_q <= link.sclk;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      conversion_clock_q <= 1'b0;
    end else begin
      conversion_clock_q <= link.conversion_clock;
    end
  end

  assign sclk_rise = link.sclk & ~sclk_q;
  assign sclk_fall = ~link.sclk & sclk_q;
  assign conversion_clock_rise = link.conversion_clock & ~conversion_clock_q;

  // window closes 9 serial edges (4.5 cycles) after the fourth rise
  assign conv_start = (state == DEV_SAMPLE) && !link.cs_b && (sclk_rise || sclk_fall)
                      && (cnt == `SACS_CNT_W'(`SACS_SAMPLE_EDGES - 1));
  assign conv_done  = (state == DEV_CONVERT) && conversion_clock_rise
                      && (cnt == `SACS_CNT_W'(`SACS_CONV_CCLKS - 1));

  // a rise with chip select high carries no select bit
  assign addr_rise   = (state == DEV_ADDR) && !link.cs_b && sclk_rise;
  assign last_select = addr_rise && (cnt == `SACS_CNT_W'(`SACS_SEL_BITS - 1));

  // sequence: select bits, sampling window, conversion
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state <= DEV_ADDR;
    end else begin
      unique case (state)
        DEV_ADDR: begin
          if (last_select) begin
            // fourth rise: justification bit and start of sampling
            state <= DEV_SAMPLE;
          end
        end
        DEV_SAMPLE: begin
          // losing chip select mid-window abandons the exchange
          if (link.cs_b) begin
            state <= DEV_ADDR;
          end else if (conv_start) begin
            state <= DEV_CONVERT;
          end
        end
        DEV_CONVERT: begin
          // conversion ignores chip select so a high pulse keeps the result
          if (conv_done) begin
            state <= DEV_ADDR;
          end
        end
        default: begin
          // the unused code of the state word can only come from an upset
          state <= DEV_ADDR;
        end
      endcase
    end
  end

  // one counter serves every phase and restarts at each phase change
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cnt <= '0;
    end else begin
      unique case (state)
        DEV_ADDR: begin
          if (link.cs_b || last_select) begin
            cnt <= '0;
          end else if (sclk_rise) begin
            cnt <= cnt + `SACS_CNT_W'(1);
          end
        end
        DEV_SAMPLE: begin
          // both edges count, so 9 of them make the 4.5-cycle window
          if (link.cs_b || conv_start) begin
            cnt <= '0;
          end else if (sclk_rise || sclk_fall) begin
            cnt <= cnt + `SACS_CNT_W'(1);
          end
        end
        DEV_CONVERT: begin
          if (conv_done) begin
            cnt <= '0;
          end else if (conversion_clock_rise) begin
            cnt <= cnt + `SACS_CNT_W'(1);
          end
        end
        default: begin
          cnt <= '0;
        end
      endcase
    end
  end

  // select bits enter on rises; the fourth rise fixes channel and format
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      addr_sr          <= '0;
      right_just       <= 1'b0;
      selected_channel <= '0;
    end else if (addr_rise) begin
      addr_sr <= {addr_sr[`SACS_ADDR_BITS-2:0], link.serial_in};
      if (last_select) begin
        right_just       <= link.serial_in;
        selected_channel <= addr_sr;
      end
    end
  end

  assign sampling = (state == DEV_SAMPLE);

  // one-hot pick: each channel gates its own word, then all are or-ed
  for (genvar ch = 0; ch < `SACS_CHANNELS; ch++) begin : g_pick
    assign gated[ch] = (selected_channel == `SACS_ADDR_BITS'(ch)) ? analog_in[ch] : '0;
  end

  always_comb begin
    picked = '0;
    for (int k = 0; k < `SACS_CHANNELS; k++) begin
      picked = picked | gated[k];
    end
  end

  // track only inside the window, then freeze
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      held <= '0;
    end else if (state == DEV_SAMPLE && !link.cs_b) begin
      held <= picked;
    end
  end

  // busy comes from a flop so the host sees no glitch between phases
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      busy <= 1'b0;
    end else if (conv_start) begin
      busy <= 1'b1;
    end else if (conv_done) begin
      busy <= 1'b0;
    end
  end

  assign link.conversion_busy = busy;

  // falls before the first rise after a load would skip the first bit
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rise_seen <= 1'b0;
    end else if (conv_done) begin
      rise_seen <= 1'b0;
    end else if (!link.cs_b && sclk_rise) begin
      rise_seen <= 1'b1;
    end
  end

  // result shift-out; zeros fill behind so a drained register reads zero
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      shift_reg <= '0;
    end else if (conv_done) begin
      // new result replaces the old at conversion end, whether or not the old was read out
      shift_reg <= right_just ? {`SACS_PAD_BITS'(0), held}
                              : {held, `SACS_PAD_BITS'(0)};
    end else if (!link.cs_b && sclk_fall && rise_seen) begin
      shift_reg <= {shift_reg[`SACS_RIGHT_BITS-2:0], 1'b0};
    end
  end

  // the pin is enabled exactly while chip select is low
  assign link.serial_out      = shift_reg[`SACS_RIGHT_BITS-1];
  assign link.serial_out_oe_b = link.cs_b;

endmodule : sacs_device

// File: rtl/sacs_host.sv
// host side: shared clock divider, busy-aligned exchange with chip select held low
`timescale 1ns/100ps
`include "sacs_defs.svh"
module sacs_host
  import sacs_pkg::*;
(
  input  wire logic                           clock,
  input  wire logic                           rst_b,
  sacs_link_if.host                           link,
  input  wire logic [`SACS_ADDR_BITS-1:0]     channel,
  input  wire logic                           right_just,
  output logic      [`SACS_RES_BITS-1:0]      result,
  output logic                                result_valid,
  output logic                                exchange_active
);

  sacs_host_state_e               state;
  logic [`SACS_CNT_W-1:0]         div_cnt;
  logic                           sclk_r;
  logic                           tick;
  logic                           busy_q;
  logic                           busy_fall;
  logic [`SACS_CNT_W-1:0]         cnt;
  logic [`SACS_SEL_BITS-1:0]      cfg;
  logic                           fmt_right;
  logic [`SACS_RIGHT_BITS-1:0]    data_sr;
  logic [`SACS_RIGHT_BITS-1:0]    next_data_sr;
  logic                           sin_r;

  // shared clock kept at or below 1 MHz; it never stops, so busy does the pacing
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      div_cnt <= '0;
      sclk_r  <= 1'b0;
    end else if (tick) begin
      div_cnt <= '0;
      sclk_r  <= ~sclk_r;
    end else begin
      div_cnt <= div_cnt + `SACS_CNT_W'(1);
    end
  end

  assign tick = (div_cnt == `SACS_CNT_W'(`SACS_SCLK_HALF_CYC - 1));
  assign link.sclk             = sclk_r;
  assign link.conversion_clock = sclk_r;
  assign link.cs_b             = 1'b0;
  assign link.serial_in        = sin_r;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      busy_q <= 1'b0;
    end else begin
      busy_q <= link.conversion_busy;
    end
  end

  assign busy_fall    = busy_q & ~link.conversion_busy;
  assign next_data_sr = {data_sr[`SACS_RIGHT_BITS-2:0], link.serial_out};

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state        <= HOST_XFER;
      cnt          <= '0;
      cfg          <= '0;
      fmt_right    <= 1'b0;
      data_sr      <= '0;
      sin_r        <= 1'b0;
      result       <= '0;
      result_valid <= 1'b0;
    end else begin
      result_valid <= 1'b0;
      if (busy_fall) begin
        // the data now out belongs to the select sent last time
        state     <= HOST_XFER;
        cnt       <= '0;
        fmt_right <= cfg[0];
        cfg       <= {channel, right_just};
        sin_r     <= channel[`SACS_ADDR_BITS-1];
      end else if (state == HOST_XFER && tick) begin
        if (!sclk_r) begin
          data_sr <= next_data_sr;
          cnt     <= cnt + `SACS_CNT_W'(1);
          if (cnt == (fmt_right ? `SACS_CNT_W'(`SACS_RIGHT_BITS - 1)
                                : `SACS_CNT_W'(`SACS_LEFT_BITS - 1))) begin
            result       <= next_data_sr[`SACS_RES_BITS-1:0];
            result_valid <= 1'b1;
            state        <= HOST_WAIT;
          end
        end else if (cnt != '0 && cnt < `SACS_CNT_W'(`SACS_SEL_BITS)) begin
          sin_r <= cfg[`SACS_SEL_BITS - 1 - 32'(cnt)];
        end else if (cnt >= `SACS_CNT_W'(`SACS_SEL_BITS)) begin
          sin_r <= 1'b0;
        end
      end
    end
  end

  assign exchange_active = (state == HOST_XFER);

endmodule : sacs_host

// File: rtl/sacs_link_if.sv
// serial link between the converter sequencer and its host
`timescale 1ns/100ps
interface sacs_link_if;
  logic sclk;
  logic conversion_clock;
  logic cs_b;
  logic serial_in;
  logic serial_out;
  logic serial_out_oe_b;
  logic conversion_busy;
  modport dev (
    input  sclk,
    input  conversion_clock,
    input  cs_b,
    input  serial_in,
    output serial_out,
    output serial_out_oe_b,
    output conversion_busy
  );
  modport host (
    output sclk,
    output conversion_clock,
    output cs_b,
    output serial_in,
    input  serial_out,
    input  serial_out_oe_b,
    input  conversion_busy
  );
endinterface : sacs_link_if

// File: rtl/sacs_pkg.sv
// types shared by the sequencer and its host end
package sacs_pkg;
  typedef enum logic [1:0] {
    DEV_ADDR,
    DEV_SAMPLE,
    DEV_CONVERT
  } sacs_dev_state_e;
  typedef enum logic {
    HOST_XFER,
    HOST_WAIT
  } sacs_host_state_e;
endpackage : sacs_pkg

// File: sim/sacs_link_properties.sv
// link checks for the shared-clock exchange with chip select held low
`timescale 1ns/100ps
module sacs_link_properties (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic sclk,
  input wire logic conversion_clock,
  input wire logic cs_b,
  input wire logic serial_in,
  input wire logic serial_out,
  input wire logic serial_out_oe_b,
  input wire logic conversion_busy
);
  logic       sclk_d;
  logic [7:0] half_cnt;
  logic [5:0] busy_cnt;
  logic [3:0] rise_cnt;
  logic       just_bit;
  wire        rise_seen = sclk & ~sclk_d;
  wire        fall_seen = ~sclk & sclk_d;
  default clocking dc @(posedge clock); endclocking
  default disable iff (!rst_b);
  // edge detect mirrors the device's one-clock registered view of sclk
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      sclk_d   <= 1'b0;
      half_cnt <= 8'h00;
      busy_cnt <= 6'h00;
      rise_cnt <= 4'h0;
      just_bit <= 1'b0;
    end else begin
      sclk_d   <= sclk;
      half_cnt <= (sclk != sclk_d) ? 8'h01 : half_cnt + 8'h01;
      busy_cnt <= !conversion_busy ? 6'h00 : busy_cnt + {5'h00, rise_seen};
      rise_cnt <= conversion_busy ? 4'h0 : rise_cnt + {3'h0, rise_seen && rise_cnt != 4'hF};
      if (rise_seen && !conversion_busy && rise_cnt == 4'h3) begin
        just_bit <= serial_in;
      end
    end
  end
  chk_oe_follows_cs: assert property (serial_out_oe_b == cs_b)
    else $error("output enable differs from chip select");
  chk_cs_held_low: assert property (cs_b == 1'b0)
    else $error("chip select left low state");
  chk_clocks_tied: assert property (conversion_clock == sclk)
    else $error("conversion clock differs from serial clock");
  chk_sclk_half_period: assert property ((sclk != sclk_d) |-> half_cnt >= 8'h7C && half_cnt <= 8'h7D)
    else $error("serial clock half period too short or long");
  chk_busy_width: assert property ($fell(conversion_busy) |-> busy_cnt == 6'h29)
    else $error("busy not high for 41 conversion clocks");
  chk_busy_start: assert property ($rose(conversion_busy) |-> rise_cnt == 4'h8 && !sclk && half_cnt <= 8'h03)
    else $error("conversion started at wrong point of exchange");
  chk_out_on_fall: assert property ($changed(serial_out) |-> $past(fall_seen) || $past(fall_seen, 2) || $fell(conversion_busy))
    else $error("serial output changed off a clock fall");
  chk_right_lead_zero: assert property ($fell(conversion_busy) && just_bit |-> serial_out == 1'b0)
    else $error("right justified result lacks leading zero");
  chk_select_stable: assert property (rise_seen |-> $stable(serial_in))
    else $error("select bit moved at a clock rise");
endmodule : sacs_link_properties

// File: sim/serial_adc_conversion_sequencer_tb.sv
// bench joining host and converter ends over the shared-clock link
`timescale 1ns/100ps
`include "sacs_defs.svh"
module serial_adc_conversion_sequencer_tb;
  logic                                          clock;
  logic                                          rst_b;
  logic [`SACS_CHANNELS-1:0][`SACS_RES_BITS-1:0] analog_in;
  logic [2:0]                                    channel;
  logic [2:0]                                    selected_channel;
  logic                                          right_just;
  logic                                          sampling;
  logic [9:0]                                    result;
  logic                                          result_valid;
  logic                                          exchange_active;
  logic [9:0]                                    snap;
  logic                                          cur_rj;
  logic [9:0]                                    res_q[$];
  logic [2:0]                                    ch_q[$];
  logic                                          rj_q[$];
  int                                            num_errors;
  int                                            samples_checked;
  int                                            nb;
  sacs_link_if link ();
  sacs_device sacs_device_i (.clock(clock), .rst_b(rst_b), .link(link), .analog_in(analog_in),
    .selected_channel(selected_channel), .sampling(sampling));
  sacs_host sacs_host_i (.clock(clock), .rst_b(rst_b), .link(link), .channel(channel),
    .right_just(right_just), .result(result), .result_valid(result_valid),
    .exchange_active(exchange_active));
  sacs_link_properties sacs_link_properties_i (.clock(clock), .rst_b(rst_b), .sclk(link.sclk),
    .conversion_clock(link.conversion_clock), .cs_b(link.cs_b), .serial_in(link.serial_in),
    .serial_out(link.serial_out), .serial_out_oe_b(link.serial_out_oe_b),
    .conversion_busy(link.conversion_busy));
  function automatic logic first_bit(input logic rj, input logic [9:0] v);
    return rj ? 1'b0 : v[9];
  endfunction : first_bit
  task automatic check(input logic [9:0] seen, input logic [9:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic stop_test();
    $display("errors %0d, checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : stop_test
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  // analog moves only outside the window; select moves only while busy, so the host's capture is clean
  always @(negedge clock) if (rst_b === 1'b1) begin
    if (sampling !== 1'b1) analog_in[$urandom_range(7)] <= 10'($urandom);
    if (link.conversion_busy === 1'b1) begin
      channel <= (nb == 1) ? 3'h7 : 3'($urandom);
      right_just <= (nb == 1) ? 1'b1 : 1'($urandom);
    end
  end
  always @(negedge sampling) if (rst_b === 1'b1) begin
    snap = analog_in[selected_channel];
    res_q.push_back(snap);
  end
  always @(posedge sampling) if (rst_b === 1'b1) begin
    @(negedge clock);
    check(10'(selected_channel), 10'(ch_q.pop_front()));
    check(10'(exchange_active), 10'h001);
    cur_rj = rj_q.pop_front();
  end
  always @(negedge link.conversion_busy) if (rst_b === 1'b1) begin
    nb++;
    ch_q.push_back(channel);
    rj_q.push_back(right_just);
    #1 check(10'(link.serial_out), 10'(first_bit(cur_rj, snap)));
  end
  always @(negedge clock) if (result_valid === 1'b1) begin
    check(result, res_q.pop_front());
    check(10'(exchange_active), 10'h000);
  end
  initial begin
    #(95000 * 4);
    num_errors++;
    $display("unexpected at %0t: run did not finish", $time);
    stop_test();
  end
  initial begin
    rst_b = 1'b0;
    channel = 3'h0;
    right_just = 1'b0;
    analog_in = '0;
    num_errors = 0;
    samples_checked = 0;
    nb = 0;
    res_q = {10'h000};
    ch_q = {3'h0};
    rj_q = {1'b0};
    void'($urandom(32'hA743BA0F));
    repeat (12) @(posedge clock);
    @(negedge clock);
    rst_b = 1'b1;
    repeat (6) @(posedge result_valid);
    repeat (2) @(negedge clock);
    stop_test();
  end
endmodule : serial_adc_conversion_sequencer_tb
